// *** inc/cpr_pkg.sv ***
// Shared constants and types for the cascaded interrupt priority resolver.
package cpr_pkg;

    // ----------------------------------------------------------------
    // Geometry and fixed wiring
    // ----------------------------------------------------------------
    localparam int NUM_LINES = 8;
    localparam int LINE_W = 3;
    localparam logic [2:0] CASCADE_LINE = 3'h2;
    localparam logic [2:0] CAS_SLAVE_ID = 3'h2;
    localparam logic [2:0] CAS_IDLE = 3'h0;
    localparam logic [2:0] SPURIOUS_LINE = 3'h7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] RESET_LOWEST = 3'h7;
    localparam logic [4:0] RESET_BASE = 5'h04;
    localparam logic [7:0] LINES_NONE = 8'h00;
    localparam logic [7:0] LINES_ALL = 8'hff;

    // ----------------------------------------------------------------
    // Acknowledge sequence and run-time commands
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACK_IDLE = 2'h0,
        ACK_FIRST = 2'h1,
        ACK_GAP = 2'h3,
        ACK_SECOND = 2'h2
    } cpr_ack_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SPEC_EOI = 3'h1,
        OP_NONSPEC_EOI = 3'h2,
        OP_ROTATE_SPECIFIC = 3'h3,
        OP_AUTO_ROT_ON = 3'h4,
        OP_AUTO_ROT_OFF = 3'h5,
        OP_SMASK_ON = 3'h6,
        OP_SMASK_OFF = 3'h7
    } cpr_op_t;

    typedef struct packed {
        logic edge_mode;
        logic special_nested;
        logic auto_eoi;
        logic [4:0] vector_base;
    } cpr_init_t;

    typedef struct packed {
        logic valid;
        logic to_slave;
        cpr_op_t op;
        logic [2:0] line;
    } cpr_cmd_t;

    typedef struct packed {
        cpr_init_t init;
        logic [7:0] pending;
        logic [7:0] in_service;
        logic [2:0] lowest;
        logic special_mask;
        logic auto_rotate;
    } cpr_ctl_t;

    localparam cpr_init_t INIT_RESET = '{edge_mode: 1'b1, special_nested: 1'b0,
                                         auto_eoi: 1'b0, vector_base: RESET_BASE};
    localparam cpr_ctl_t CTL_RESET = '{init: INIT_RESET, pending: LINES_NONE,
                                       in_service: LINES_NONE, lowest: RESET_LOWEST,
                                       special_mask: 1'b0, auto_rotate: 1'b0};

endpackage

// *** verilog/cpr_prio_resolve.sv ***
// Level ordering and eligibility check for one eight-line controller.
`timescale 1ns/100ps
module cpr_prio_resolve #(
    parameter int LINES = cpr_pkg::NUM_LINES
) (
    // Line state
    input wire logic [7:0] req,
    input wire logic [7:0] in_service,
    input wire logic [2:0] lowest,
    // Nesting mode
    input wire logic special_nested,
    input wire logic special_mask,
    // Result
    output logic fwd_valid,
    output logic [2:0] fwd_line,
    output logic top_isr_valid,
    output logic [2:0] top_isr_line
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (LINES != 8) begin : g_bad_lines
        $error("cpr_prio_resolve serves exactly eight lines");
    end

    // ----------------------------------------------------------------
    // Ordering
    // ----------------------------------------------------------------
    // Position 0 is the highest level; the line after the lowest one leads.
    function automatic logic [2:0] level_of(input logic [2:0] ln, input logic [2:0] low);
        return 3'(ln - low - 3'h1);
    endfunction

    logic win_valid;
    logic [2:0] win_line;
    logic allow;

    always_comb begin
        logic [2:0] ln;
        ln = 3'h0;
        win_valid = 1'b0;
        win_line = 3'h0;
        top_isr_valid = 1'b0;
        top_isr_line = 3'h0;
        for (int i = 0; i < LINES; i++) begin
            ln = 3'(lowest + 3'(i) + 3'h1);
            if (!top_isr_valid && in_service[ln]) begin
                top_isr_valid = 1'b1;
                top_isr_line = ln;
            end
            // Under special mask only the lines in service are blocked.
            if (!win_valid && req[ln] && !(special_mask && in_service[ln])) begin
                win_valid = 1'b1;
                win_line = ln;
            end
        end
        if (special_mask || !top_isr_valid) begin
            allow = win_valid;
        end else if (special_nested) begin
            allow = win_valid &&
                    (level_of(win_line, lowest) <= level_of(top_isr_line, lowest));
        end else begin
            allow = win_valid &&
                    (level_of(win_line, lowest) < level_of(top_isr_line, lowest));
        end
        fwd_valid = allow;
        fwd_line = win_line;
    end

endmodule

// *** verilog/cpr_resolver_top.sv ***
// Cascaded master and slave interrupt priority resolver with acknowledge sequencing.
`timescale 1ns/100ps
// Behaviour
// - Default order line 0 highest, 7 lowest.
// - Specific rotation makes named line lowest.
// - Auto rotation makes serviced line lowest.
// - Fully nested forwards only strictly higher requests.
// - Slave requests appear on master line 2.
// - Special nested lets equal level preempt too.
// - Special mask blocks only in-service lines.
// - Vector is base in bits 7:3, line number in bits 2:0.
// - Per-line pending, mask, in-service; mask blocks.
// - Master acknowledge clears edge-mode pending, sets in-service.
// - Slave request sets slave and master pending.
// - Selected slave takes acknowledge, supplies vector.
// - Eligibility compares requests against in-service bits.
// - Auto end-of-interrupt only in master.
// - Specific end-of-interrupt clears the named line.
// - Nonspecific end-of-interrupt clears highest in service.
// - Lines are edge-triggered or level-sensitive.
// - Two strobe pulses; master drives cascade select.
module cpr_resolver_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Initialization
    input wire logic INIT_STROBE,
    input wire cpr_pkg::cpr_init_t MASTER_INIT,
    input wire cpr_pkg::cpr_init_t SLAVE_INIT,
    // Run-time control
    input wire cpr_pkg::cpr_cmd_t CMD,
    input wire logic [7:0] MASTER_MASK,
    input wire logic [7:0] SLAVE_MASK,
    // Request lines
    input wire logic [7:0] MASTER_REQUEST_LINE,
    input wire logic [7:0] SLAVE_REQUEST_LINE,
    // Processor core
    input wire logic ACKNOWLEDGE_STROBE_N,
    output logic INT_REQ,
    output logic [2:0] CASCADE_SELECT_BUS,
    output logic CASCADE_DRIVE,
    output logic [7:0] VECTOR,
    output logic VECTOR_VALID,
    // Status
    output logic [7:0] MASTER_PENDING,
    output logic [7:0] MASTER_IN_SERVICE,
    output logic [7:0] SLAVE_PENDING,
    output logic [7:0] SLAVE_IN_SERVICE,
    output logic [2:0] MASTER_LOWEST,
    output logic [2:0] SLAVE_LOWEST
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        cpr_pkg::cpr_ack_t ack;
        logic strobe_prev;
        logic [7:0] m_sync1;
        logic [7:0] m_sync2;
        logic [7:0] m_prev;
        logic [7:0] s_sync1;
        logic [7:0] s_sync2;
        logic [7:0] s_prev;
        cpr_pkg::cpr_ctl_t m;
        cpr_pkg::cpr_ctl_t s;
        logic [2:0] ack_line;
        logic ack_real;
        logic [2:0] cas;
        logic cas_drive;
        logic [7:0] vector;
        logic vector_valid;
        logic int_req;
    } cpr_state_t;

    localparam cpr_state_t STATE_RESET = '{
        ack: cpr_pkg::ACK_IDLE, strobe_prev: 1'b1,
        m_sync1: cpr_pkg::LINES_NONE, m_sync2: cpr_pkg::LINES_NONE,
        m_prev: cpr_pkg::LINES_NONE, s_sync1: cpr_pkg::LINES_NONE,
        s_sync2: cpr_pkg::LINES_NONE, s_prev: cpr_pkg::LINES_NONE,
        m: cpr_pkg::CTL_RESET, s: cpr_pkg::CTL_RESET,
        ack_line: cpr_pkg::SPURIOUS_LINE, ack_real: 1'b0,
        cas: cpr_pkg::CAS_IDLE, cas_drive: 1'b0,
        vector: cpr_pkg::LINES_NONE, vector_valid: 1'b0, int_req: 1'b0};

    cpr_state_t st_ff;
    cpr_state_t nxt_st;

    // ----------------------------------------------------------------
    // Per-controller update
    // ----------------------------------------------------------------
    // Clears are applied before sets, so a request or acknowledge in the same
    // cycle as an ending command is never lost.
    function automatic cpr_pkg::cpr_ctl_t ctl_step(
        input cpr_pkg::cpr_ctl_t c,
        input logic [7:0] raw,
        input logic [7:0] prev,
        input logic take,
        input logic [2:0] take_ln,
        input logic [7:0] clr_mask,
        input logic [2:0] rot_ln,
        input logic cmd_hit,
        input cpr_pkg::cpr_cmd_t cmd
    );
        cpr_pkg::cpr_ctl_t n;
        logic [7:0] held;
        logic [7:0] rise;
        n = c;
        rise = raw & ~prev;
        // Level-sensitive pending drops with the line; edge pending is sticky.
        held = c.pending & (c.init.edge_mode ? cpr_pkg::LINES_ALL : raw);
        if (take) begin
            held[take_ln] = 1'b0;
        end
        n.pending = held | (c.init.edge_mode ? rise : raw);
        n.in_service = c.in_service & ~clr_mask;
        if (clr_mask != cpr_pkg::LINES_NONE && c.auto_rotate) begin
            n.lowest = rot_ln;
        end
        if (take) begin
            n.in_service[take_ln] = 1'b1;
        end
        if (cmd_hit) begin
            unique case (cmd.op)
                cpr_pkg::OP_NONE: ;
                cpr_pkg::OP_SPEC_EOI: ;
                cpr_pkg::OP_NONSPEC_EOI: ;
                cpr_pkg::OP_ROTATE_SPECIFIC: n.lowest = cmd.line;
                cpr_pkg::OP_AUTO_ROT_ON: n.auto_rotate = 1'b1;
                cpr_pkg::OP_AUTO_ROT_OFF: n.auto_rotate = 1'b0;
                cpr_pkg::OP_SMASK_ON: n.special_mask = 1'b1;
                cpr_pkg::OP_SMASK_OFF: n.special_mask = 1'b0;
            endcase
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // Priority resolution
    // ----------------------------------------------------------------
    logic s_fwd_valid;
    logic [2:0] s_fwd_line;
    logic s_top_valid;
    logic [2:0] s_top_line;
    logic m_fwd_valid;
    logic [2:0] m_fwd_line;
    logic m_top_valid;
    logic [2:0] m_top_line;
    logic [7:0] m_raw;

    cpr_prio_resolve #(.LINES(cpr_pkg::NUM_LINES)) u_slave_resolve (
        .req(st_ff.s.pending & ~SLAVE_MASK),
        .in_service(st_ff.s.in_service),
        .lowest(st_ff.s.lowest),
        .special_nested(st_ff.s.init.special_nested),
        .special_mask(st_ff.s.special_mask),
        .fwd_valid(s_fwd_valid),
        .fwd_line(s_fwd_line),
        .top_isr_valid(s_top_valid),
        .top_isr_line(s_top_line)
    );

    cpr_prio_resolve #(.LINES(cpr_pkg::NUM_LINES)) u_master_resolve (
        .req(st_ff.m.pending & ~MASTER_MASK),
        .in_service(st_ff.m.in_service),
        .lowest(st_ff.m.lowest),
        .special_nested(st_ff.m.init.special_nested),
        .special_mask(st_ff.m.special_mask),
        .fwd_valid(m_fwd_valid),
        .fwd_line(m_fwd_line),
        .top_isr_valid(m_top_valid),
        .top_isr_line(m_top_line)
    );

    // The slave's forwarded request replaces the pin on master line 2.
    always_comb begin
        m_raw = st_ff.m_sync2;
        m_raw[cpr_pkg::CASCADE_LINE] = s_fwd_valid;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic fall;
        logic rise;
        logic m_take;
        logic s_take;
        logic [2:0] s_take_ln;
        logic m_hit;
        logic s_hit;
        logic [7:0] m_clr;
        logic [7:0] s_clr;
        logic [2:0] m_rot;
        logic [2:0] s_rot;
        fall = st_ff.strobe_prev & ~ACKNOWLEDGE_STROBE_N;
        rise = ~st_ff.strobe_prev & ACKNOWLEDGE_STROBE_N;
        m_take = 1'b0;
        s_take = 1'b0;
        s_take_ln = s_fwd_line;
        m_hit = CMD.valid && !CMD.to_slave;
        s_hit = CMD.valid && CMD.to_slave;
        m_clr = cpr_pkg::LINES_NONE;
        s_clr = cpr_pkg::LINES_NONE;
        m_rot = m_top_line;
        s_rot = s_top_line;
        nxt_st = st_ff;

        nxt_st.strobe_prev = ACKNOWLEDGE_STROBE_N;
        nxt_st.m_sync1 = MASTER_REQUEST_LINE;
        nxt_st.m_sync2 = st_ff.m_sync1;
        nxt_st.s_sync1 = SLAVE_REQUEST_LINE;
        nxt_st.s_sync2 = st_ff.s_sync1;
        nxt_st.m_prev = m_raw;
        nxt_st.s_prev = st_ff.s_sync2;

        // Acknowledge: first pulse commits the master, second yields the vector.
        unique case (st_ff.ack)
            cpr_pkg::ACK_IDLE: begin
                if (fall) begin
                    nxt_st.ack = cpr_pkg::ACK_FIRST;
                    m_take = m_fwd_valid;
                    nxt_st.ack_real = m_fwd_valid;
                    nxt_st.ack_line = m_fwd_valid ? m_fwd_line : cpr_pkg::SPURIOUS_LINE;
                    nxt_st.cas_drive = 1'b1;
                    nxt_st.cas = (m_fwd_valid && m_fwd_line == cpr_pkg::CASCADE_LINE) ?
                                 cpr_pkg::CAS_SLAVE_ID : cpr_pkg::CAS_IDLE;
                end
            end
            cpr_pkg::ACK_FIRST: begin
                if (rise) begin
                    nxt_st.ack = cpr_pkg::ACK_GAP;
                end
            end
            cpr_pkg::ACK_GAP: begin
                if (fall) begin
                    nxt_st.ack = cpr_pkg::ACK_SECOND;
                    nxt_st.vector_valid = 1'b1;
                    if (st_ff.cas == cpr_pkg::CAS_SLAVE_ID) begin
                        s_take = s_fwd_valid;
                        s_take_ln = s_fwd_line;
                        nxt_st.vector = {st_ff.s.init.vector_base,
                                         s_fwd_valid ? s_fwd_line :
                                         cpr_pkg::SPURIOUS_LINE};
                    end else begin
                        nxt_st.vector = {st_ff.m.init.vector_base, st_ff.ack_line};
                    end
                end
            end
            cpr_pkg::ACK_SECOND: begin
                if (rise) begin
                    nxt_st.ack = cpr_pkg::ACK_IDLE;
                    nxt_st.vector_valid = 1'b0;
                    nxt_st.cas_drive = 1'b0;
                    nxt_st.cas = cpr_pkg::CAS_IDLE;
                    // Only the master ends its own interrupts automatically.
                    if (st_ff.m.init.auto_eoi && st_ff.ack_real) begin
                        m_clr[st_ff.ack_line] = 1'b1;
                        m_rot = st_ff.ack_line;
                    end
                end
            end
        endcase

        // Ending commands share the clear mask with the automatic ending.
        if (m_hit && CMD.op == cpr_pkg::OP_SPEC_EOI) begin
            m_clr[CMD.line] = 1'b1;
            m_rot = CMD.line;
        end else if (m_hit && CMD.op == cpr_pkg::OP_NONSPEC_EOI && m_top_valid) begin
            m_clr[m_top_line] = 1'b1;
        end
        if (s_hit && CMD.op == cpr_pkg::OP_SPEC_EOI) begin
            s_clr[CMD.line] = 1'b1;
            s_rot = CMD.line;
        end else if (s_hit && CMD.op == cpr_pkg::OP_NONSPEC_EOI && s_top_valid) begin
            s_clr[s_top_line] = 1'b1;
        end

        nxt_st.m = ctl_step(st_ff.m, m_raw, st_ff.m_prev, m_take, m_fwd_line,
                            m_clr, m_rot, m_hit, CMD);
        nxt_st.s = ctl_step(st_ff.s, st_ff.s_sync2, st_ff.s_prev, s_take, s_take_ln,
                            s_clr, s_rot, s_hit, CMD);

        nxt_st.int_req = m_fwd_valid;

        // Initialization restores default ordering and takes the new modes.
        if (INIT_STROBE) begin
            nxt_st.m = cpr_pkg::CTL_RESET;
            nxt_st.s = cpr_pkg::CTL_RESET;
            nxt_st.m.init = MASTER_INIT;
            nxt_st.s.init = SLAVE_INIT;
            nxt_st.s.init.auto_eoi = 1'b0;
            nxt_st.int_req = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_ff <= STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign INT_REQ = st_ff.int_req;
    assign CASCADE_SELECT_BUS = st_ff.cas;
    assign CASCADE_DRIVE = st_ff.cas_drive;
    assign VECTOR = st_ff.vector;
    assign VECTOR_VALID = st_ff.vector_valid;
    assign MASTER_PENDING = st_ff.m.pending;
    assign MASTER_IN_SERVICE = st_ff.m.in_service;
    assign SLAVE_PENDING = st_ff.s.pending;
    assign SLAVE_IN_SERVICE = st_ff.s.in_service;
    assign MASTER_LOWEST = st_ff.m.lowest;
    assign SLAVE_LOWEST = st_ff.s.lowest;

endmodule

// *** bench/cpr_resolver_properties.sv ***
// Concurrent checks on the resolver top-level ports.
`timescale 1ns/100ps
module cpr_resolver_properties (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Control
    input wire logic INIT_STROBE,
    input wire cpr_pkg::cpr_cmd_t CMD,
    input wire logic [7:0] MASTER_MASK,
    input wire logic ACKNOWLEDGE_STROBE_N,
    // Answers
    input wire logic INT_REQ,
    input wire logic [2:0] CASCADE_SELECT_BUS,
    input wire logic CASCADE_DRIVE,
    input wire logic [7:0] VECTOR,
    input wire logic VECTOR_VALID,
    // Status
    input wire logic [7:0] MASTER_PENDING,
    input wire logic [7:0] MASTER_IN_SERVICE,
    input wire logic [7:0] SLAVE_IN_SERVICE,
    input wire logic [2:0] MASTER_LOWEST
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // ----
    // Acknowledge steps
    // ----
    sequence s_first_fall;
        $fell(ACKNOWLEDGE_STROBE_N) && !CASCADE_DRIVE;
    endsequence
    sequence s_ack_pair;
        s_first_fall ##1 ACKNOWLEDGE_STROBE_N [*2] ##1 !ACKNOWLEDGE_STROBE_N;
    endsequence

    // A master command that no acknowledge edge can override in its cycle.
    logic quiet;
    assign quiet = CMD.valid && !CMD.to_slave && !INIT_STROBE && ACKNOWLEDGE_STROBE_N
        && !VECTOR_VALID;

    a_int_cause:
    assert property (INT_REQ |-> ($past(MASTER_PENDING) & ~$past(MASTER_MASK)) != 8'h00)
        else $error("request raised with no unmasked pending line");
    a_cas_first:
    assert property (s_first_fall |=> CASCADE_DRIVE)
        else $error("cascade select not driven after first pulse");
    a_vec_pair:
    assert property (s_ack_pair |=> VECTOR_VALID && CASCADE_DRIVE)
        else $error("vector not presented after second pulse");
    a_vec_master:
    assert property ($rose(VECTOR_VALID) && CASCADE_SELECT_BUS == cpr_pkg::CAS_IDLE
        |-> MASTER_IN_SERVICE[VECTOR[2:0]] || VECTOR[2:0] == cpr_pkg::SPURIOUS_LINE)
        else $error("master vector line not in service");
    a_vec_slave:
    assert property ($rose(VECTOR_VALID) && CASCADE_SELECT_BUS == cpr_pkg::CAS_SLAVE_ID
        |-> SLAVE_IN_SERVICE[VECTOR[2:0]] || VECTOR[2:0] == cpr_pkg::SPURIOUS_LINE)
        else $error("slave vector line not in service");
    a_spec_eoi:
    assert property (quiet && CMD.op == cpr_pkg::OP_SPEC_EOI
        |=> !MASTER_IN_SERVICE[$past(CMD.line)])
        else $error("specific ending left named line in service");
    a_nonspec_eoi:
    assert property (quiet && CMD.op == cpr_pkg::OP_NONSPEC_EOI && MASTER_IN_SERVICE != 8'h00
        |=> $countones($past(MASTER_IN_SERVICE)) == $countones(MASTER_IN_SERVICE) + 1)
        else $error("nonspecific ending did not clear exactly one line");
    a_rotate_spec:
    assert property (quiet && CMD.op == cpr_pkg::OP_ROTATE_SPECIFIC
        |=> MASTER_LOWEST == $past(CMD.line))
        else $error("specific rotation did not set lowest line");
    a_init_clear:
    assert property (INIT_STROBE |=> MASTER_PENDING == 8'h00 && MASTER_IN_SERVICE == 8'h00
        && MASTER_LOWEST == cpr_pkg::RESET_LOWEST)
        else $error("initialization did not restore default order");
endmodule

bind cpr_resolver_top cpr_resolver_properties u_props (.CLK(CLK), .RST_N(RST_N),
    .INIT_STROBE(INIT_STROBE), .CMD(CMD), .MASTER_MASK(MASTER_MASK),
    .ACKNOWLEDGE_STROBE_N(ACKNOWLEDGE_STROBE_N), .INT_REQ(INT_REQ),
    .CASCADE_SELECT_BUS(CASCADE_SELECT_BUS), .CASCADE_DRIVE(CASCADE_DRIVE), .VECTOR(VECTOR),
    .VECTOR_VALID(VECTOR_VALID), .MASTER_PENDING(MASTER_PENDING),
    .MASTER_IN_SERVICE(MASTER_IN_SERVICE), .SLAVE_IN_SERVICE(SLAVE_IN_SERVICE),
    .MASTER_LOWEST(MASTER_LOWEST));

// *** bench/cpr_core_model.sv ***
// Processor core model issuing two-pulse acknowledge cycles.
`timescale 1ns/100ps
module cpr_core_model (
    // Clock and control
    input wire logic clk,
    input wire logic go,
    // Resolver answer
    input wire logic vec_valid,
    input wire logic [7:0] vec,
    // Strobe and result
    output logic strobe_n,
    output logic done,
    output logic [7:0] vec_cap
);
    int ph = 0;
    initial begin
        strobe_n = 1'b1;
        done = 1'b0;
        vec_cap = 8'h00;
    end
    // Low, high, high, low, high: the spare high cycle keeps pulses apart.
    always @(negedge clk) begin
        if (ph != 0 || go) begin
            ph <= (ph == 6) ? 0 : ph + 1;
        end
        strobe_n <= !((ph == 0 && go) || ph == 3);
        done <= (ph == 6);
    end
    always @(posedge clk) begin
        if (vec_valid) begin
            vec_cap <= vec;
        end
    end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the cascaded interrupt priority resolver.
`timescale 1ns/100ps
module tb_top;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic INIT_STROBE = 1'b0;
    cpr_pkg::cpr_init_t MASTER_INIT = cpr_pkg::INIT_RESET;
    cpr_pkg::cpr_init_t SLAVE_INIT = cpr_pkg::INIT_RESET;
    cpr_pkg::cpr_cmd_t CMD = '0;
    logic [7:0] MASTER_MASK = 8'h00;
    logic [7:0] SLAVE_MASK = 8'h00;
    logic [7:0] MASTER_REQUEST_LINE = 8'h00;
    logic [7:0] SLAVE_REQUEST_LINE = 8'h00;
    logic ACKNOWLEDGE_STROBE_N, INT_REQ, CASCADE_DRIVE, VECTOR_VALID, ack_done;
    logic [2:0] CASCADE_SELECT_BUS, MASTER_LOWEST, SLAVE_LOWEST;
    logic [7:0] VECTOR, MASTER_PENDING, MASTER_IN_SERVICE, SLAVE_PENDING, SLAVE_IN_SERVICE;
    logic [7:0] ack_vec;
    logic ack_go = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    localparam cpr_pkg::cpr_init_t S_DEF = '{1'b1, 1'b0, 1'b0, 5'h05};

    cpr_resolver_top u_dut (.CLK(CLK), .RST_N(RST_N), .INIT_STROBE(INIT_STROBE),
        .MASTER_INIT(MASTER_INIT), .SLAVE_INIT(SLAVE_INIT), .CMD(CMD),
        .MASTER_MASK(MASTER_MASK), .SLAVE_MASK(SLAVE_MASK),
        .MASTER_REQUEST_LINE(MASTER_REQUEST_LINE), .SLAVE_REQUEST_LINE(SLAVE_REQUEST_LINE),
        .ACKNOWLEDGE_STROBE_N(ACKNOWLEDGE_STROBE_N), .INT_REQ(INT_REQ),
        .CASCADE_SELECT_BUS(CASCADE_SELECT_BUS), .CASCADE_DRIVE(CASCADE_DRIVE),
        .VECTOR(VECTOR), .VECTOR_VALID(VECTOR_VALID), .MASTER_PENDING(MASTER_PENDING),
        .MASTER_IN_SERVICE(MASTER_IN_SERVICE), .SLAVE_PENDING(SLAVE_PENDING),
        .SLAVE_IN_SERVICE(SLAVE_IN_SERVICE), .MASTER_LOWEST(MASTER_LOWEST),
        .SLAVE_LOWEST(SLAVE_LOWEST));
    cpr_core_model u_core (.clk(CLK), .go(ack_go), .vec_valid(VECTOR_VALID), .vec(VECTOR),
        .strobe_n(ACKNOWLEDGE_STROBE_N), .done(ack_done), .vec_cap(ack_vec));

    initial begin
        forever #10 CLK = ~CLK;
    end

    // ----
    // Shared tasks
    // ----
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A missing request ends the run; an absent one is watched for twelve cycles.
    task automatic want_int(input logic e);
        for (int i = 0; i < 12 && INT_REQ !== 1'b1; i++) begin
            @(negedge CLK);
        end
        chk("int_req", {7'h00, e}, {7'h00, INT_REQ});
        if (e && INT_REQ !== 1'b1) final_report();
    endtask
    task automatic ack(input logic [7:0] exp);
        ack_go <= 1'b1;
        @(negedge CLK);
        ack_go <= 1'b0;
        for (int i = 0; i < 20 && ack_done !== 1'b1; i++) begin
            @(negedge CLK);
        end
        chk("vector", exp, ack_vec);
        chk("ack_done", 8'h01, {7'h00, ack_done});
        if (ack_done !== 1'b1) final_report();
    endtask
    task automatic cmd(input logic ts, input cpr_pkg::cpr_op_t op, input logic [2:0] ln);
        CMD <= '{valid: 1'b1, to_slave: ts, op: op, line: ln};
        @(negedge CLK);
        CMD <= '0;
        @(negedge CLK);
    endtask
    task automatic init(input cpr_pkg::cpr_init_t m);
        MASTER_REQUEST_LINE <= 8'h00;
        SLAVE_REQUEST_LINE <= 8'h00;
        repeat (4) @(negedge CLK);
        MASTER_INIT <= m;
        SLAVE_INIT <= S_DEF;
        INIT_STROBE <= 1'b1;
        @(negedge CLK);
        INIT_STROBE <= 1'b0;
        @(negedge CLK);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_nested();
        init('{1'b1, 1'b0, 1'b0, 5'h04});
        MASTER_REQUEST_LINE <= 8'ha8;
        want_int(1'b1);
        ack(8'h23);
        chk("m_isr", 8'h08, MASTER_IN_SERVICE);
        chk("m_pend", 8'ha0, MASTER_PENDING);
        want_int(1'b0);
        cmd(1'b0, cpr_pkg::OP_SPEC_EOI, 3'h3);
        want_int(1'b1);
        ack(8'h25);
        MASTER_REQUEST_LINE <= 8'ha9;
        want_int(1'b1);
        ack(8'h20);
        cmd(1'b0, cpr_pkg::OP_NONSPEC_EOI, 3'h0);
        chk("m_isr", 8'h20, MASTER_IN_SERVICE);
    endtask
    task automatic t_mask();
        init('{1'b1, 1'b0, 1'b0, 5'h04});
        MASTER_MASK <= 8'h02;
        MASTER_REQUEST_LINE <= 8'h02;
        want_int(1'b0);
        chk("m_pend", 8'h02, MASTER_PENDING);
        MASTER_MASK <= 8'h00;
        want_int(1'b1);
        ack(8'h21);
    endtask
    task automatic t_rotate();
        init('{1'b1, 1'b0, 1'b0, 5'h04});
        cmd(1'b0, cpr_pkg::OP_ROTATE_SPECIFIC, 3'h5);
        chk("m_low", 8'h05, {5'h00, MASTER_LOWEST});
        MASTER_REQUEST_LINE <= 8'h50;
        want_int(1'b1);
        ack(8'h26);
        cmd(1'b0, cpr_pkg::OP_AUTO_ROT_ON, 3'h0);
        cmd(1'b0, cpr_pkg::OP_NONSPEC_EOI, 3'h0);
        chk("m_low", 8'h06, {5'h00, MASTER_LOWEST});
        want_int(1'b1);
        ack(8'h24);
        cmd(1'b0, cpr_pkg::OP_SPEC_EOI, 3'h4);
        chk("m_low", 8'h04, {5'h00, MASTER_LOWEST});
    endtask
    task automatic t_cascade(input logic sn);
        init('{1'b1, sn, 1'b0, 5'h04});
        chk("s_low", 8'h07, {5'h00, SLAVE_LOWEST});
        SLAVE_REQUEST_LINE <= 8'h80;
        want_int(1'b1);
        ack(8'h2f);
        chk("m_isr", 8'h04, MASTER_IN_SERVICE);
        chk("s_isr", 8'h80, SLAVE_IN_SERVICE);
        SLAVE_REQUEST_LINE <= 8'h81;
        want_int(sn);
        chk("s_pend", 8'h01, SLAVE_PENDING);
        if (!sn) begin
            cmd(1'b1, cpr_pkg::OP_SPEC_EOI, 3'h7);
            cmd(1'b0, cpr_pkg::OP_NONSPEC_EOI, 3'h0);
        end
        want_int(1'b1);
        ack(8'h28);
    endtask
    task automatic t_smask();
        init('{1'b1, 1'b0, 1'b0, 5'h04});
        MASTER_REQUEST_LINE <= 8'h02;
        want_int(1'b1);
        ack(8'h21);
        cmd(1'b0, cpr_pkg::OP_SMASK_ON, 3'h0);
        MASTER_REQUEST_LINE <= 8'h22;
        want_int(1'b1);
        ack(8'h25);
        cmd(1'b0, cpr_pkg::OP_SPEC_EOI, 3'h1);
        chk("m_isr", 8'h20, MASTER_IN_SERVICE);
        cmd(1'b0, cpr_pkg::OP_SMASK_OFF, 3'h0);
    endtask
    task automatic t_auto_end_of_interrupt_mode_level();
        init('{1'b0, 1'b0, 1'b1, 5'h1f});
        MASTER_REQUEST_LINE <= 8'h10;
        want_int(1'b1);
        ack(8'hfc);
        chk("m_isr", 8'h00, MASTER_IN_SERVICE);
        chk("m_pend", 8'h10, MASTER_PENDING);
        MASTER_REQUEST_LINE <= 8'h00;
        repeat (4) @(negedge CLK);
        chk("m_pend", 8'h00, MASTER_PENDING);
    endtask

    initial begin
        repeat (2) @(negedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(negedge CLK);
        t_nested();
        t_mask();
        t_rotate();
        t_cascade(1'b0);
        t_cascade(1'b1);
        t_smask();
        t_auto_end_of_interrupt_mode_level();
        final_report();
    end
endmodule
